//--- rtl/sld_regs.svh
// register offsets, opcodes, log pages and codes of the sct log decoder
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH
// ------------------------------------------------------------
// apb byte offsets
// ------------------------------------------------------------
`define SLD_OFF_FEAT     8'h00
`define SLD_OFF_SCNT     8'h04
`define SLD_OFF_LBAL     8'h08
`define SLD_OFF_LBAM     8'h0c
`define SLD_OFF_LBAH     8'h10
`define SLD_OFF_DEV      8'h14
`define SLD_OFF_CMD      8'h18
`define SLD_OFF_RESULT   8'h1c
`define SLD_OFF_EXTSTAT  8'h20
`define SLD_OFF_INTSTAT  8'h24
`define SLD_OFF_INTMASK  8'h28
// ------------------------------------------------------------
// ata opcodes, features, log pages, signature
// ------------------------------------------------------------
`define SLD_CMD_SMART    8'hb0
`define SLD_CMD_RDLOGX   8'h2f
`define SLD_CMD_WRLOGX   8'h3f
`define SLD_FEAT_RD      8'hd5
`define SLD_FEAT_WR      8'hd6
`define SLD_LOG_DATA     8'he1
`define SLD_LOG_STAT     8'he0
`define SLD_SIG_LO       8'h4f
`define SLD_SIG_HI       8'hc2
`define SLD_ONE_SECT     8'h01
`define SLD_ZERO_BYTE    8'h00
`define SLD_DEV_UNIT_BIT 4
// ------------------------------------------------------------
// extended status codes and reset values
// ------------------------------------------------------------
`define SLD_EXT_OK       16'h0000
`define SLD_EXT_NOSCT    16'h000b
`define SLD_EXT_BUSY     16'hffff
`define SLD_ZERO_WORD    32'h0000_0000
// ------------------------------------------------------------
// interrupt bits
// ------------------------------------------------------------
`define SLD_INT_W        4
`define SLD_INT_ACC      0
`define SLD_INT_ABT      1
`define SLD_INT_STAT     2
`define SLD_INT_NOSCT    3
`endif

//--- rtl/sld_pkg.sv
// types shared by the sct log decoder modules
package sld_pkg;
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_DATA_RD,
    KIND_DATA_WR,
    KIND_STAT_RD
  } sld_kind_t;

  typedef struct packed {
    logic      done;
    logic      accept;
    logic      no_sct;
    logic      ext;
    sld_kind_t kind;
    logic [15:0] count;
  } sld_dec_state_t;
endpackage

//--- rtl/sld_dec_if.sv
// carrier between register front end and command decoder
interface sld_dec_if;
  logic                go;
  logic [7:0]          cmd;
  logic [7:0]          feat;
  logic [15:0]         scnt;
  logic [7:0]          lba_lo;
  logic [15:0]         lba_mid;
  logic [7:0]          lba_hi;
  logic                sct_seen;
  logic                done;
  logic                accept;
  logic                no_sct;
  logic                ext;
  sld_pkg::sld_kind_t  kind;
  logic [15:0]         count;

  modport front (output go, cmd, feat, scnt, lba_lo, lba_mid, lba_hi,
                 sct_seen,
                 input done, accept, no_sct, ext, kind, count);
  modport dec   (input go, cmd, feat, scnt, lba_lo, lba_mid, lba_hi,
                 sct_seen,
                 output done, accept, no_sct, ext, kind, count);
endinterface

//--- rtl/sld_decoder.sv
// task-file decoder: one-cycle classification of sct log requests
`include "sld_regs.svh"
module sld_decoder (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // task file in, verdict out
  sld_dec_if.dec   dif
);
  sld_pkg::sld_dec_state_t st_ff;
  sld_pkg::sld_dec_state_t nxt_st;
  logic                    sig_ok;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.done   = 1'b0;
    sig_ok        = (dif.lba_mid[7:0] == `SLD_SIG_LO) &&
                    (dif.lba_hi == `SLD_SIG_HI);
    if (dif.go) begin
      nxt_st.done   = 1'b1;
      nxt_st.accept = 1'b0;
      nxt_st.no_sct = 1'b0;
      nxt_st.ext    = 1'b0;
      nxt_st.kind   = sld_pkg::KIND_NONE;
      nxt_st.count  = dif.scnt;
      case (dif.cmd)
        `SLD_CMD_SMART: begin
          nxt_st.count = {`SLD_ZERO_BYTE, dif.scnt[7:0]};
          if (sig_ok && dif.lba_lo == `SLD_LOG_DATA) begin
            if (dif.feat == `SLD_FEAT_RD) begin
              nxt_st.kind = sld_pkg::KIND_DATA_RD;
            end else if (dif.feat == `SLD_FEAT_WR) begin
              nxt_st.kind = sld_pkg::KIND_DATA_WR;
            end
          end else if (sig_ok && dif.lba_lo == `SLD_LOG_STAT &&
                       dif.feat == `SLD_FEAT_RD &&
                       dif.scnt[7:0] == `SLD_ONE_SECT) begin
            nxt_st.kind = sld_pkg::KIND_STAT_RD;
          end
        end
        `SLD_CMD_RDLOGX: begin
          nxt_st.ext = 1'b1;
          if (dif.lba_lo == `SLD_LOG_DATA) begin
            nxt_st.kind = sld_pkg::KIND_DATA_RD;
          end else if (dif.lba_lo == `SLD_LOG_STAT) begin
            nxt_st.kind = sld_pkg::KIND_STAT_RD;
          end
        end
        `SLD_CMD_WRLOGX: begin
          nxt_st.ext = 1'b1;
          if (dif.lba_lo == `SLD_LOG_DATA) begin
            nxt_st.kind = sld_pkg::KIND_DATA_WR;
          end
        end
        default: begin
          nxt_st.kind = sld_pkg::KIND_NONE;
        end
      endcase
      // data page only makes sense after an sct command
      if ((nxt_st.kind == sld_pkg::KIND_DATA_RD ||
           nxt_st.kind == sld_pkg::KIND_DATA_WR) && !dif.sct_seen) begin
        nxt_st.no_sct = 1'b1;
        nxt_st.kind   = sld_pkg::KIND_NONE;
      end
      nxt_st.accept = (nxt_st.kind != sld_pkg::KIND_NONE);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dif.done   = st_ff.done;
  assign dif.accept = st_ff.accept;
  assign dif.no_sct = st_ff.no_sct;
  assign dif.ext    = st_ff.ext;
  assign dif.kind   = st_ff.kind;
  assign dif.count  = st_ff.count;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_smart_bad_sig: assert property (
    dif.go && dif.cmd == `SLD_CMD_SMART &&
    dif.lba_hi != `SLD_SIG_HI |=> dif.done && !dif.accept)
    else $error("smart request with bad signature accepted");
  chk_smart_feat_dir: assert property (
    dif.go && dif.cmd == `SLD_CMD_SMART && dif.sct_seen &&
    dif.lba_lo == `SLD_LOG_DATA && dif.feat == `SLD_FEAT_WR &&
    dif.lba_mid[7:0] == `SLD_SIG_LO && dif.lba_hi == `SLD_SIG_HI
    |=> dif.kind == sld_pkg::KIND_DATA_WR)
    else $error("smart write feature not decoded as write");
  chk_ext_stat_page: assert property (
    dif.go && dif.cmd == `SLD_CMD_RDLOGX && dif.lba_lo == `SLD_LOG_STAT
    |=> dif.accept && dif.kind == sld_pkg::KIND_STAT_RD && dif.ext)
    else $error("extended status read not decoded");
  chk_no_sct_data: assert property (
    dif.go && !dif.sct_seen && dif.cmd == `SLD_CMD_WRLOGX &&
    dif.lba_lo == `SLD_LOG_DATA |=> dif.no_sct && !dif.accept)
    else $error("data transfer without sct command not flagged");
endmodule

//--- rtl/sld_log_access.sv
// apb front end of the sct log access decoder
`include "sld_regs.svh"
module sld_log_access (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // sct action handler
  input  wire logic        sct_cmd_issue,
  input  wire logic        sct_busy,
  input  wire logic        sct_code_vld,
  input  wire logic [15:0] sct_code,
  // transfer engine and ata status
  output logic             xfer_start,
  output logic             xfer_write,
  output logic [15:0]      xfer_count,
  output logic             xfer_unit,
  output logic             stat_page_start,
  output logic             ata_accept,
  output logic             ata_abort,
  output logic [15:0]      ext_status,
  // interrupt
  output logic             irq
);
  typedef struct packed {
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic [15:0]          feat;
    logic [15:0]          scnt;
    logic [7:0]           lbal;
    logic [15:0]          lbam;
    logic [7:0]           lbah;
    logic                 unit;
    logic [7:0]           cmd;
    logic                 go;
    logic                 pend;
    logic                 sct_seen;
    logic [15:0]          code;
    logic                 res_acc;
    logic                 res_abt;
    logic                 res_ext;
    sld_pkg::sld_kind_t   res_kind;
    logic [15:0]          res_count;
    logic [`SLD_INT_W-1:0] int_stat;
    logic [`SLD_INT_W-1:0] int_mask;
    logic                 irq;
    logic                 xfer_start;
    logic                 xfer_write;
    logic [15:0]          xfer_count;
    logic                 stat_start;
    logic                 ata_acc;
    logic                 ata_abt;
    logic [15:0]          ext_status;
  } sld_front_t;

  sld_front_t            st_ff;
  sld_front_t            nxt_st;
  sld_dec_if             dif ();
  logic                  acc_phase;
  logic                  wr_en;
  logic                  hit;
  logic [31:0]           rd_word;
  logic [`SLD_INT_W-1:0] ev;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] pair16(input logic [15:0] v);
    pair16 = {16'h0000, v};
  endfunction

  function automatic logic [31:0] byte8(input logic [7:0] v);
    byte8 = {24'h000000, v};
  endfunction

  // ------------------------------------------------------------
  // decoder
  // ------------------------------------------------------------
  sld_decoder u_dec (
    .mclk (mclk),
    .rst  (rst),
    .dif  (dif)
  );

  assign dif.go       = st_ff.go;
  assign dif.cmd      = st_ff.cmd;
  assign dif.feat     = st_ff.feat[7:0];
  assign dif.scnt     = st_ff.scnt;
  assign dif.lba_lo   = st_ff.lbal;
  assign dif.lba_mid  = st_ff.lbam;
  assign dif.lba_hi   = st_ff.lbah;
  assign dif.sct_seen = st_ff.sct_seen;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    acc_phase = psel && penable && !st_ff.pready;
    wr_en     = acc_phase && pwrite;
    hit       = 1'b1;
    rd_word   = `SLD_ZERO_WORD;
    ev        = '0;
    case (paddr)
      `SLD_OFF_FEAT:    rd_word = pair16(st_ff.feat);
      `SLD_OFF_SCNT:    rd_word = pair16(st_ff.scnt);
      `SLD_OFF_LBAL:    rd_word = byte8(st_ff.lbal);
      `SLD_OFF_LBAM:    rd_word = pair16(st_ff.lbam);
      `SLD_OFF_LBAH:    rd_word = byte8(st_ff.lbah);
      `SLD_OFF_DEV:     rd_word = byte8(8'(st_ff.unit) <<
                                        `SLD_DEV_UNIT_BIT);
      `SLD_OFF_CMD:     rd_word = byte8(st_ff.cmd);
      `SLD_OFF_RESULT:  rd_word = {st_ff.res_count, 8'h00, 2'b00,
                                   st_ff.pend, st_ff.res_ext,
                                   st_ff.res_kind, st_ff.res_abt,
                                   st_ff.res_acc};
      `SLD_OFF_EXTSTAT: rd_word = pair16(st_ff.ext_status);
      `SLD_OFF_INTSTAT: rd_word = {28'h0000000, st_ff.int_stat};
      `SLD_OFF_INTMASK: rd_word = {28'h0000000, st_ff.int_mask};
      default:          hit     = 1'b0;
    endcase

    // apb: one wait state, data and error registered with pready
    nxt_st.pready  = acc_phase;
    nxt_st.pslverr = acc_phase && !hit;
    nxt_st.prdata  = (acc_phase && !pwrite && hit) ? rd_word
                                                   : `SLD_ZERO_WORD;

    nxt_st.go = 1'b0;
    if (wr_en) begin
      case (paddr)
        `SLD_OFF_FEAT:    nxt_st.feat = pwdata[15:0];
        `SLD_OFF_SCNT:    nxt_st.scnt = pwdata[15:0];
        `SLD_OFF_LBAL:    nxt_st.lbal = pwdata[7:0];
        `SLD_OFF_LBAM:    nxt_st.lbam = pwdata[15:0];
        `SLD_OFF_LBAH:    nxt_st.lbah = pwdata[7:0];
        // other device-register bits are don't-care for these requests
        `SLD_OFF_DEV:     nxt_st.unit = pwdata[`SLD_DEV_UNIT_BIT];
        `SLD_OFF_CMD: begin
          // a command while one is in decode is dropped
          if (!st_ff.pend) begin
            nxt_st.cmd  = pwdata[7:0];
            nxt_st.go   = 1'b1;
            nxt_st.pend = 1'b1;
          end
        end
        `SLD_OFF_INTMASK: nxt_st.int_mask = pwdata[`SLD_INT_W-1:0];
        default: begin
          nxt_st.go = 1'b0;
        end
      endcase
    end

    // verdict from the decoder
    nxt_st.xfer_start = 1'b0;
    nxt_st.stat_start = 1'b0;
    nxt_st.ata_acc    = 1'b0;
    nxt_st.ata_abt    = 1'b0;
    if (dif.done) begin
      nxt_st.pend      = 1'b0;
      nxt_st.res_acc   = dif.accept;
      nxt_st.res_abt   = !dif.accept;
      nxt_st.res_ext   = dif.ext;
      nxt_st.res_kind  = dif.kind;
      nxt_st.res_count = dif.count;
      // acceptance only; action completion is seen by polling status
      nxt_st.ata_acc   = dif.accept;
      nxt_st.ata_abt   = !dif.accept;
      ev[`SLD_INT_ACC] = dif.accept;
      ev[`SLD_INT_ABT] = !dif.accept;
      if (dif.kind == sld_pkg::KIND_STAT_RD) begin
        // served whatever sct_busy says; nothing else is touched
        nxt_st.stat_start = 1'b1;
        ev[`SLD_INT_STAT] = 1'b1;
      end else if (dif.accept) begin
        nxt_st.xfer_start = 1'b1;
        nxt_st.xfer_write = (dif.kind == sld_pkg::KIND_DATA_WR);
        nxt_st.xfer_count = dif.count;
      end
      if (dif.no_sct) begin
        nxt_st.code        = `SLD_EXT_NOSCT;
        ev[`SLD_INT_NOSCT] = 1'b1;
      end
    end

    // handler updates win over the decoder's own code
    if (sct_cmd_issue) begin
      nxt_st.sct_seen = 1'b1;
    end
    if (sct_code_vld) begin
      nxt_st.code = sct_code;
    end
    nxt_st.ext_status = sct_busy ? `SLD_EXT_BUSY : nxt_st.code;

    // write one to clear, a new event in the same cycle stays set
    if (wr_en && paddr == `SLD_OFF_INTSTAT) begin
      nxt_st.int_stat = st_ff.int_stat & ~pwdata[`SLD_INT_W-1:0];
    end
    nxt_st.int_stat = nxt_st.int_stat | ev;
    nxt_st.irq      = |(nxt_st.int_stat & nxt_st.int_mask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.code <= `SLD_EXT_OK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pready          = st_ff.pready;
  assign prdata          = st_ff.prdata;
  assign pslverr         = st_ff.pslverr;
  assign xfer_start      = st_ff.xfer_start;
  assign xfer_write      = st_ff.xfer_write;
  assign xfer_count      = st_ff.xfer_count;
  assign xfer_unit       = st_ff.unit;
  assign stat_page_start = st_ff.stat_start;
  assign ata_accept      = st_ff.ata_acc;
  assign ata_abort       = st_ff.ata_abt;
  assign ext_status      = st_ff.ext_status;
  assign irq             = st_ff.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_cmd_write;
    psel && penable && pwrite && !pready && paddr == `SLD_OFF_CMD &&
    !st_ff.pend;
  endsequence

  // verdict shows three edges after the command write is taken
  sequence s_verdict;
    ##3 (ata_accept ^ ata_abort);
  endsequence

  sequence s_ext_go;
    s_cmd_write ##1 (dif.go && dif.cmd == `SLD_CMD_RDLOGX);
  endsequence

  chk_ata_one_verdict: assert property (
    s_cmd_write |-> s_verdict)
    else $error("command write gave no single ata verdict");

  chk_stat_while_busy: assert property (
    s_cmd_write ##1 (dif.go && dif.cmd == `SLD_CMD_RDLOGX &&
                     dif.lba_lo == `SLD_LOG_STAT)
    |-> ##2 stat_page_start && ata_accept)
    else $error("status read refused");

  chk_stat_no_side: assert property (
    stat_page_start && !sct_code_vld && !sct_busy &&
    !$past(sct_code_vld) |-> !xfer_start && $stable(st_ff.code))
    else $error("status read disturbed background state");

  chk_busy_code: assert property (
    sct_busy |=> ext_status == `SLD_EXT_BUSY)
    else $error("busy code not shown while sct runs");

  chk_nosct_code: assert property (
    dif.done && dif.no_sct && !sct_code_vld && !sct_busy
    |=> ext_status == `SLD_EXT_NOSCT)
    else $error("missing-command code not reported");

  chk_smart_count: assert property (
    s_cmd_write ##1 (dif.go && dif.cmd == `SLD_CMD_SMART)
    ##1 (dif.done && dif.accept && dif.kind != sld_pkg::KIND_STAT_RD)
    |=> xfer_start && xfer_count == {8'h00, $past(st_ff.scnt[7:0], 2)})
    else $error("smart transfer length wrong");

  chk_apb_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");

  chk_ext_length: assert property (
    s_ext_go ##1 (dif.done && dif.accept &&
                  dif.kind == sld_pkg::KIND_DATA_RD)
    |=> xfer_start && !xfer_write &&
        xfer_count == $past(st_ff.scnt, 2))
    else $error("log-ext read length or direction wrong");

  chk_stat_page_only: assert property (
    stat_page_start |-> ata_accept && !xfer_start &&
                        st_ff.int_stat[`SLD_INT_STAT])
    else $error("status page start without its verdict");

  chk_abort_quiet: assert property (
    ata_abort |-> !xfer_start && !stat_page_start && !ata_accept &&
                  st_ff.int_stat[`SLD_INT_ABT])
    else $error("aborted request started a transfer");

  // a status read while busy must leave the held code alone
  chk_busy_code_kept: assert property (
    sct_busy && !sct_code_vld && !(dif.done && dif.no_sct)
    |=> $stable(st_ff.code))
    else $error("code lost while sct action runs");

  chk_nosct_irq: assert property (
    dif.done && dif.no_sct |=> ata_abort &&
                               st_ff.int_stat[`SLD_INT_NOSCT])
    else $error("missing-command abort not flagged");

  chk_err_no_data: assert property (
    pslverr |-> pready && prdata == `SLD_ZERO_WORD)
    else $error("error answer carried data");

  chk_idle_rdata: assert property (
    !pready |-> prdata == `SLD_ZERO_WORD && !pslverr)
    else $error("read data outside the answer cycle");

  chk_verdict_pulse: assert property (
    ata_accept || ata_abort |=> !ata_accept && !ata_abort)
    else $error("ata verdict held longer than one cycle");

  chk_xfer_pulse: assert property (
    xfer_start |=> !xfer_start)
    else $error("transfer start held longer than one cycle");

  chk_pend_clear: assert property (
    s_cmd_write |=> st_ff.pend ##2 !st_ff.pend)
    else $error("pending flag not cleared by the verdict");
endmodule

//--- test/sld_host_model.sv
// apb host model issuing task-file commands to the sct log decoder
`include "sld_regs.svh"
module sld_host_model (
  // clock
  input  wire logic        mclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rd_q;
  logic        err_q;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released data flips so a stale word is never taken for a new one
    pwdata  <= ~d;
  endtask
  // host keeps log-ext counts and lba-mid as required of it
  task automatic issue(input logic [7:0] c, f, input logic [15:0] sc,
                       input logic [7:0] ll, input logic [15:0] lm,
                       input logic [7:0] lh, input logic unit);
    xfer(1'b1, `SLD_OFF_FEAT, {24'h0, f});
    xfer(1'b1, `SLD_OFF_SCNT, {16'h0, sc});
    xfer(1'b1, `SLD_OFF_LBAL, {24'h0, ll});
    xfer(1'b1, `SLD_OFF_LBAM, {16'h0, lm});
    xfer(1'b1, `SLD_OFF_LBAH, {24'h0, lh});
    xfer(1'b1, `SLD_OFF_DEV, {27'h0, unit, 4'h0});
    xfer(1'b1, `SLD_OFF_CMD, {24'h0, c});
  endtask
endmodule

//--- test/sct_log_access_decoder_tb.sv
// self-checking bench of the sct log access decoder
`include "sld_regs.svh"
module sct_log_access_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sct_cmd_issue = 1'b0;
  logic        sct_busy = 1'b0;
  logic        sct_code_vld = 1'b0;
  logic [15:0] sct_code = 16'h0000;
  logic        xfer_start, xfer_write, xfer_unit, stat_page_start;
  logic        ata_accept, ata_abort, irq;
  logic [15:0] xfer_count, ext_status, xc_q;
  logic        xw_q, xu_q;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          n_xs = 0, n_st = 0, n_acc = 0, n_abt = 0;
  always #25 mclk = ~mclk;
  sld_log_access DUT (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sct_cmd_issue(sct_cmd_issue), .sct_busy(sct_busy),
    .sct_code_vld(sct_code_vld), .sct_code(sct_code),
    .xfer_start(xfer_start), .xfer_write(xfer_write),
    .xfer_count(xfer_count), .xfer_unit(xfer_unit),
    .stat_page_start(stat_page_start), .ata_accept(ata_accept),
    .ata_abort(ata_abort), .ext_status(ext_status), .irq(irq));
  sld_host_model host (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  // one-cycle pulses are counted here so no task can miss one
  always @(posedge mclk) begin
    if (xfer_start === 1'b1) begin
      n_xs++;
      xw_q = xfer_write;
      xc_q = xfer_count;
      xu_q = xfer_unit;
    end
    if (stat_page_start === 1'b1) n_st++;
    if (ata_accept === 1'b1) n_acc++;
    if (ata_abort === 1'b1) n_abt++;
  end
  // ----------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000);
    chk(host.rd_q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
    repeat (2) @(negedge mclk);
  endtask
  task automatic handler(input logic [15:0] c, input logic iss);
    @(posedge mclk);
    sct_code_vld <= 1'b1;
    sct_code <= c;
    sct_cmd_issue <= iss;
    @(posedge mclk);
    sct_code_vld <= 1'b0;
    sct_cmd_issue <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // exp: 0 abort, 1 data read, 2 data write, 3 status page
  task automatic run_cmd(input logic [7:0] c, f, input logic [15:0] sc,
                         input logic [7:0] ll, input logic [15:0] lm,
                         input logic [7:0] lh, input logic unit,
                         input int exp, input logic [15:0] cnt);
    int a0, b0, x0, s0, i;
    a0 = n_acc;
    b0 = n_abt;
    x0 = n_xs;
    s0 = n_st;
    host.issue(c, f, sc, ll, lm, lh, unit);
    i = 0;
    while (n_acc == a0 && n_abt == b0 && i < 20) begin
      @(posedge mclk);
      i++;
    end
    @(negedge mclk);
    chk(n_abt - b0, exp == 0);
    chk(n_acc - a0, exp != 0);
    chk(n_xs - x0, exp == 1 || exp == 2);
    chk(n_st - s0, exp == 3);
    if (exp == 1 || exp == 2) begin
      chk(xw_q, exp == 2);
      chk(xc_q, cnt);
      chk(xu_q, unit);
    end
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    rd_chk(`SLD_OFF_RESULT, 32'h0000_0000);
    rd_chk(`SLD_OFF_EXTSTAT, 32'h0000_0000);
    host.xfer(1'b0, 8'h40, 32'h0000_0000);
    chk(host.err_q, 1'b1);
    chk(host.rd_q, 32'h0000_0000);
    chk(irq, 1'b0);
  endtask
  task automatic t_no_sct;
    run_cmd(8'hb0, 8'hd5, 16'h0001, 8'he1, 16'h004f, 8'hc2, 0, 0, 0);
    chk(ext_status, 16'h000b);
    rd_chk(`SLD_OFF_INTSTAT, 32'h0000_000a);
    handler(16'h0000, 1'b1);
    chk(ext_status, 16'h0000);
  endtask
  task automatic t_decode;
    run_cmd(8'hb0, 8'hd5, 16'h0005, 8'he1, 16'h004f, 8'hc2, 1, 1, 5);
    run_cmd(8'hb0, 8'hd6, 16'h0103, 8'he1, 16'h004f, 8'hc2, 0, 2, 3);
    rd_chk(`SLD_OFF_RESULT, 32'h0003_0009);
    run_cmd(8'h2f, 8'h00, 16'h0001, 8'he1, 16'h0000, 8'h00, 0, 1, 1);
    run_cmd(8'h3f, 8'h00, 16'h0001, 8'he1, 16'h0000, 8'h00, 1, 2, 1);
    rd_chk(`SLD_OFF_RESULT, 32'h0001_0019);
    run_cmd(8'hb0, 8'hd5, 16'h0001, 8'he0, 16'h004f, 8'hc2, 0, 3, 0);
    run_cmd(8'h2f, 8'h00, 16'h0001, 8'he0, 16'h0000, 8'h00, 0, 3, 0);
    run_cmd(8'hb0, 8'hd5, 16'h0001, 8'he1, 16'h004e, 8'hc2, 0, 0, 0);
    run_cmd(8'hb0, 8'hd5, 16'h0001, 8'he1, 16'h004f, 8'hc3, 0, 0, 0);
    run_cmd(8'hb0, 8'hd5, 16'h0001, 8'he2, 16'h004f, 8'hc2, 0, 0, 0);
    run_cmd(8'hb0, 8'hd5, 16'h0002, 8'he0, 16'h004f, 8'hc2, 0, 0, 0);
    run_cmd(8'hb0, 8'hd6, 16'h0001, 8'he0, 16'h004f, 8'hc2, 0, 0, 0);
  endtask
  task automatic t_busy;
    @(posedge mclk);
    sct_busy <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(ext_status, 16'hffff);
    run_cmd(8'hb0, 8'hd5, 16'h0001, 8'he0, 16'h004f, 8'hc2, 0, 3, 0);
    chk(ext_status, 16'hffff);
    rd_chk(`SLD_OFF_EXTSTAT, 32'h0000_ffff);
    handler(16'h0003, 1'b0);
    @(posedge mclk);
    sct_busy <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(ext_status, 16'h0003);
  endtask
  task automatic t_irq;
    wr(`SLD_OFF_INTSTAT, 32'h0000_000f);
    wr(`SLD_OFF_INTMASK, 32'h0000_0004);
    rd_chk(`SLD_OFF_INTMASK, 32'h0000_0004);
    chk(irq, 1'b0);
    run_cmd(8'h2f, 8'h00, 16'h0001, 8'he0, 16'h0000, 8'h00, 0, 3, 0);
    repeat (2) @(negedge mclk);
    chk(irq, 1'b1);
    wr(`SLD_OFF_INTMASK, 32'h0000_0000);
    chk(irq, 1'b0);
    wr(`SLD_OFF_INTMASK, 32'h0000_0004);
    chk(irq, 1'b1);
    wr(`SLD_OFF_INTSTAT, 32'h0000_000f);
    chk(irq, 1'b0);
    rd_chk(`SLD_OFF_INTSTAT, 32'h0000_0000);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_no_sct;
    t_decode;
    t_busy;
    t_irq;
    test_done;
  end
  // the whole run needs about 550 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done;
  end
endmodule
